/* rtl/cts_supervisor.sv */
// Two-instance current transformer supervision with register port, events and logs
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE1: Blocking input sampled at each program cycle start
// RULE2: Pick-up without blocking raises start, starts timing
// RULE3: Pick-up with blocking raises blocked, nothing more
// RULE4: Late blocking drops start, releases like reset
// RULE5: Blocking source must lead operate delay 5 ms
// RULE6: Operate delay is definite time only
// RULE7: Alarm only after uninterrupted conditions reach delay
// RULE8: Any phase above high limit inhibits activation
// RULE9: All phases below low limit inhibit activation
// RULE10: Selected residual compared against summed phases
// RULE11: Residual difference below limit withholds activation
// RULE12: Magnitude and angle difference reported continuously
// RULE13: Two instances with alarm and block events
// RULE14: Selectable on/off events carry time stamp
// RULE15: Clearable counter of alarm and blocked events
// RULE16: Twelve newest log records per instance
// RULE17: Log record holds stamp, currents, status, group
// RULE18: Limits use 97 and 103 percent hysteresis
// RULE19: Min/max phase ratio must meet threshold
// RULE20: Negative/positive sequence ratio must meet threshold
module cts_supervisor #(
    parameter int PROG_CYC = cts_pkg::PROG_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [6:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire cts_pkg::cts_meas_s [1:0] meas,
    input wire logic [1:0] block_in,
    input wire logic [47:0] rtc_ms,
    input wire logic [2:0] set_group,
    output logic [1:0] start_out,
    output logic [1:0] alarm_out,
    output logic [1:0] blocked_out,
    output logic [7:0] event_out,
    output logic [47:0] event_ts
);
    import cts_pkg::*;

    cts_st_s s;
    cts_st_s n;
    cts_cnd_s [NINST-1:0] cnd;
    logic tick_end;

    function automatic logic [31:0] mul(input logic [15:0] a, input logic [15:0] b);
        return 32'(a) * 32'(b);
    endfunction

    // Activation conditions of one instance from its settings and measurements
    function automatic cts_cnd_s eval_cond(input cts_inst_s st, input cts_meas_s m);
        logic [15:0] mx, mn, i0, i0a;
        logic signed [16:0] a;
        logic rat, unb, dif;
        cts_cnd_s c;
        mx = (m.il1 > m.il2) ? m.il1 : m.il2;
        mx = (m.il3 > mx) ? m.il3 : mx;
        mn = (m.il1 < m.il2) ? m.il1 : m.il2;
        mn = (m.il3 < mn) ? m.il3 : mn;
        // High inhibit holds until every phase falls under 97 % of the limit
        c.hinh = (mx > st.high) || (st.hinh && !(mul(mx, HYS_REF) < mul(st.high, HYS_LO))); // [RULE8] [RULE18]
        // Low inhibit holds until some phase rises over 103 % of the limit
        c.linh = (mx < st.low) || (st.linh && !(mul(mx, HYS_REF) > mul(st.low, HYS_HI))); // [RULE9] [RULE18]
        rat = mul(mn, PCT_FULL) <= mul(mx, st.rmm); // [RULE19]
        unb = mul(m.i2, PCT_FULL) >= mul(m.i1, st.run); // [RULE20]
        i0 = (st.sel == 2'h1) ? m.i01 : m.i02;
        i0a = (st.sel == 2'h1) ? m.i01_ang : m.i02_ang;
        // Scalar magnitude difference; the front end supplies the summed phase vector
        c.mdiff = (m.isum > i0) ? m.isum - i0 : i0 - m.isum; // [RULE10] [RULE12]
        a = $signed({m.isum_ang[15], m.isum_ang}) - $signed({i0a[15], i0a});
        if (st.dir) begin
            a = a + ANG_HALF;
        end
        if (a > ANG_HALF) begin
            a = a - ANG_FULL;
        end else if (a < -ANG_HALF) begin
            a = a + ANG_FULL;
        end
        c.adiff = a[15:0]; // [RULE12]
        dif = (st.sel == 2'h0) || (c.mdiff >= st.dlim); // [RULE11]
        c.fault = {dif, unb, rat, !c.linh, !c.hinh};
        c.pu = &c.fault;
        return c;
    endfunction

    // Register read view of one instance
    function automatic logic [31:0] rd_inst(input cts_inst_s st, input logic [5:0] off);
        logic [191:0] rb;
        logic [5:0] w;
        logic [31:0] d;
        rb = (st.lsel < 4'(LOG_DEPTH)) ? st.log[st.lsel] : '0;
        w = off - OFS_LOG;
        d = 32'h0000_0000;
        case (off)
            OFS_LIM: d = {st.low, st.high};
            OFS_RAT: d = {st.run, st.rmm};
            OFS_RES: d = {8'h00, st.een, 1'b0, st.dir, st.sel, st.dlim};
            OFS_DLY: d = {16'h0000, st.dly};
            OFS_STAT: d = {12'h000, st.wptr, 7'h00, st.fault, st.blk, st.blocked, st.alarm, st.start};
            OFS_CNT: d = {16'h0000, st.cnt};
            OFS_DIFF: d = {st.adiff, st.mdiff};
            OFS_LSEL: d = {28'h000_0000, st.lsel};
            default: begin
                if (off >= OFS_LOG && w[5:2] < 4'(LOG_WORDS)) begin
                    d = rb[w[5:2]*32 +: 32];
                end
            end
        endcase
        return d;
    endfunction

    // Conditions of both instances, recomputed every clock
    for (genvar g = 0; g < NINST; g++) begin : g_cnd
        assign cnd[g] = eval_cond(s.ins[g], meas[g]);
    end

    assign tick_end = s.tick == 20'(PROG_CYC - 1);

    // Next state: program cycle timing, supervision, events, logs and registers
    always_comb begin
        logic aon, aoff, bon, boff, wsel, clr;
        logic [5:0] off;
        cts_rec_s rec;
        aon = 1'b0;
        aoff = 1'b0;
        bon = 1'b0;
        boff = 1'b0;
        wsel = 1'b0;
        clr = 1'b0;
        off = reg_addr[5:0];
        rec = '0;
        n = s;
        n.ev = 1'b0;
        n.evt = 8'h00;
        n.rdata = 32'h0000_0000;
        // Blocking is latched on the cycle start, evaluation follows one clock later
        if (tick_end) begin
            n.tick = 20'h0_0000;
            n.ev = 1'b1;
            for (int i = 0; i < NINST; i++) begin
                n.ins[i].blk = block_in[i]; // [RULE1]
            end
        end else begin
            n.tick = s.tick + 20'h0_0001;
        end
        for (int i = 0; i < NINST; i++) begin
            n.ins[i].mdiff = cnd[i].mdiff; // [RULE12]
            n.ins[i].adiff = cnd[i].adiff;
            if (s.ev) begin
                n.ins[i].hinh = cnd[i].hinh;
                n.ins[i].linh = cnd[i].linh;
                n.ins[i].fault = cnd[i].fault;
                if (cnd[i].pu && !s.ins[i].blk) begin
                    n.ins[i].start = 1'b1; // [RULE2]
                    n.ins[i].blocked = 1'b0;
                    // Fixed delay count in program cycles, no inverse curve
                    if (s.ins[i].alarm || s.ins[i].tmr >= s.ins[i].dly) begin
                        n.ins[i].alarm = 1'b1; // [RULE6] [RULE7]
                    end else begin
                        n.ins[i].tmr = s.ins[i].tmr + 16'h0001; // [RULE7]
                    end
                end else if (cnd[i].pu) begin
                    // Blocked: start drops and timing releases as on a reset
                    n.ins[i].blocked = 1'b1; // [RULE3]
                    n.ins[i].start = 1'b0; // [RULE4]
                    n.ins[i].alarm = 1'b0;
                    n.ins[i].tmr = 16'h0000; // [RULE4]
                end else begin
                    // Any break in the conditions restarts the delay
                    n.ins[i].start = 1'b0;
                    n.ins[i].alarm = 1'b0;
                    n.ins[i].blocked = 1'b0;
                    n.ins[i].tmr = 16'h0000; // [RULE7]
                end
            end
            aon = n.ins[i].alarm && !s.ins[i].alarm;
            aoff = !n.ins[i].alarm && s.ins[i].alarm;
            bon = n.ins[i].blocked && !s.ins[i].blocked;
            boff = !n.ins[i].blocked && s.ins[i].blocked;
            // Events per instance, filtered by the on/off selection
            n.evt[i*4 +: 4] = {boff, bon, aoff, aon} & s.ins[i].een; // [RULE13] [RULE14]
            wsel = reg_wr && (reg_addr[INST_BIT] == i[0]);
            clr = wsel && (off == OFS_CNT);
            // A clear in the same cycle as an event still counts that event
            if (clr) begin
                n.ins[i].cnt = 16'h0000;
            end
            if (aon || bon) begin
                n.ins[i].cnt = (clr ? 16'h0000 : s.ins[i].cnt) + 16'h0001; // [RULE15]
                rec.ts = rtc_ms;
                rec.kind = bon;
                rec.grp = set_group;
                rec.fault = cnd[i].fault;
                rec.rem = s.ins[i].dly - s.ins[i].tmr;
                rec.il1 = meas[i].il1;
                rec.il2 = meas[i].il2;
                rec.il3 = meas[i].il3;
                rec.i01 = meas[i].i01;
                rec.i02 = meas[i].i02;
                rec.i1 = meas[i].i1;
                rec.i2 = meas[i].i2;
                n.ins[i].log[s.ins[i].wptr] = rec; // [RULE17]
                // Ring of records, newest overwrites oldest
                n.ins[i].wptr = (s.ins[i].wptr == 4'(LOG_DEPTH - 1)) ? 4'h0 : s.ins[i].wptr + 4'h1; // [RULE16]
            end
            // Setting writes; a write to the counter clears it, other read-only and unmapped offsets ignore writes
            if (wsel) begin
                case (off)
                    OFS_LIM: begin
                        n.ins[i].high = reg_wdata[15:0];
                        n.ins[i].low = reg_wdata[31:16];
                    end
                    OFS_RAT: begin
                        n.ins[i].rmm = reg_wdata[15:0];
                        n.ins[i].run = reg_wdata[31:16];
                    end
                    OFS_RES: begin
                        n.ins[i].dlim = reg_wdata[15:0];
                        n.ins[i].sel = reg_wdata[RES_SEL_LSB +: 2];
                        n.ins[i].dir = reg_wdata[RES_DIR_BIT];
                        n.ins[i].een = reg_wdata[RES_EEN_LSB +: 4];
                    end
                    OFS_DLY: n.ins[i].dly = reg_wdata[15:0];
                    OFS_LSEL: n.ins[i].lsel = reg_wdata[3:0];
                    default: ;
                endcase
            end
        end
        if (tick_end || s.ev) begin
            n.evt_ts = rtc_ms;
        end
        // Read data stand only in the cycle after the strobe
        if (reg_rd) begin
            n.rdata = rd_inst(s.ins[reg_addr[INST_BIT]], off);
        end
    end

    // Single state register, synchronous reset
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            s <= cts_rst_state();
        end else begin
            s <= n;
        end
    end

    assign reg_rdata = s.rdata;
    assign event_out = s.evt;
    assign event_ts = s.evt_ts;
    assign start_out = {s.ins[1].start, s.ins[0].start};
    assign alarm_out = {s.ins[1].alarm, s.ins[0].alarm};
    assign blocked_out = {s.ins[1].blocked, s.ins[0].blocked};

    // Checks on instance one; instance two shares the same code
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    blk_sample_a: assert property ( // [RULE1]
        tick_end |=> s.ev && s.ins[0].blk == $past(block_in[0]))
        else $error("blocking input not latched at cycle start");
    start_go_a: assert property ( // [RULE2]
        s.ev && cnd[0].pu && !s.ins[0].blk |=> s.ins[0].start && !s.ins[0].blocked)
        else $error("start missing on unblocked pick-up");
    block_stop_a: assert property ( // [RULE3]
        s.ev && cnd[0].pu && s.ins[0].blk |=> s.ins[0].blocked && !s.ins[0].alarm && s.ins[0].tmr == 16'h0000)
        else $error("blocked pick-up kept processing");
    late_block_a: assert property ( // [RULE4]
        s.ev && s.ins[0].start && s.ins[0].blk |=> !s.ins[0].start && !s.ins[0].alarm)
        else $error("start not released by late blocking");
    def_time_a: assert property ( // [RULE6]
        $rose(s.ins[0].alarm) |-> s.ins[0].start && $past(s.ins[0].tmr) >= $past(s.ins[0].dly))
        else $error("alarm before definite delay elapsed");
    alarm_drop_a: assert property ( // [RULE7]
        s.ev && !cnd[0].pu |=> !s.ins[0].alarm && !s.ins[0].start && s.ins[0].tmr == 16'h0000)
        else $error("alarm or timer kept after condition break");
    high_lim_a: assert property ( // [RULE8]
        s.ev && (meas[0].il1 > s.ins[0].high || meas[0].il2 > s.ins[0].high || meas[0].il3 > s.ins[0].high)
        |=> !s.ins[0].start && !s.ins[0].blocked)
        else $error("activation above high limit");
    low_lim_a: assert property ( // [RULE9]
        s.ev && meas[0].il1 < s.ins[0].low && meas[0].il2 < s.ins[0].low && meas[0].il3 < s.ins[0].low
        |=> !s.ins[0].start && !s.ins[0].blocked)
        else $error("activation below low limit");
    resid_hold_a: assert property ( // [RULE11]
        s.ev && s.ins[0].sel != 2'h0 && cnd[0].mdiff < s.ins[0].dlim |=> !s.ins[0].start)
        else $error("activation with small residual difference");
    cnt_step_a: assert property ( // [RULE15]
        $rose(s.ins[0].alarm) |-> s.ins[0].cnt == $past(s.ins[0].cnt) + 16'h0001 || s.ins[0].cnt == 16'h0001)
        else $error("event counter did not step");
    log_ptr_a: assert property ( // [RULE16]
        $rose(s.ins[0].blocked) |-> s.ins[0].wptr == (($past(s.ins[0].wptr) == 4'hb) ? 4'h0 : $past(s.ins[0].wptr) + 4'h1))
        else $error("log pointer did not advance");
    evt_sel_a: assert property ( // [RULE14]
        $rose(s.ins[0].alarm) |-> s.evt[0] == s.ins[0].een[0] && s.evt_ts == $past(rtc_ms))
        else $error("alarm on event not gated or stamped");

    alarm_seen_c: cover property (s.ev ##1 $rose(s.ins[0].alarm));
    block_seen_c: cover property ($rose(s.ins[0].blocked));
    late_block_c: cover property (s.ins[0].start ##1 $rose(s.ins[0].blocked));
    resid_use_c: cover property (s.ins[0].sel != 2'h0 && s.ins[0].start);
endmodule

`default_nettype wire

/* rtl/cts_pkg.sv */
// Constants, types and reset state for the current transformer supervision block
package cts_pkg;
    localparam int CLK_MHZ = 50;
    localparam int PROG_US = 1000; // Program cycle period in microseconds
    localparam int PROG_CYC = PROG_US * CLK_MHZ;
    localparam int NINST = 2;
    localparam int LOG_DEPTH = 12;
    localparam int LOG_WORDS = 6;
    localparam logic [15:0] PCT_FULL = 16'h2710; // 100.00 % in 0.01 % steps
    localparam logic [15:0] HYS_REF = 16'h0064;
    localparam logic [15:0] HYS_LO = 16'h0061; // 97 %
    localparam logic [15:0] HYS_HI = 16'h0067; // 103 %
    localparam logic signed [16:0] ANG_HALF = 17'sh0_4650; // 180.00 deg
    localparam logic signed [16:0] ANG_FULL = 17'sh0_8ca0; // 360.00 deg
    // Byte offsets inside one instance window; bit 6 of the address picks the instance
    localparam int INST_BIT = 6;
    localparam logic [5:0] OFS_LIM = 6'h00;
    localparam logic [5:0] OFS_RAT = 6'h04;
    localparam logic [5:0] OFS_RES = 6'h08;
    localparam logic [5:0] OFS_DLY = 6'h0c;
    localparam logic [5:0] OFS_STAT = 6'h10;
    localparam logic [5:0] OFS_CNT = 6'h14;
    localparam logic [5:0] OFS_DIFF = 6'h18;
    localparam logic [5:0] OFS_LSEL = 6'h1c;
    localparam logic [5:0] OFS_LOG = 6'h20;
    // Field positions in the residual control word
    localparam int RES_SEL_LSB = 16;
    localparam int RES_DIR_BIT = 18;
    localparam int RES_EEN_LSB = 20;
    // Reset values, currents in 0.01 x In, ratios in 0.01 %, delay in ms
    localparam logic [15:0] RST_HIGH = 16'h0078;
    localparam logic [15:0] RST_LOW = 16'h000a;
    localparam logic [15:0] RST_RMM = 16'h03e8;
    localparam logic [15:0] RST_RUN = 16'h1324;
    localparam logic [15:0] RST_DLIM = 16'h000a;
    localparam logic [15:0] RST_DLY = 16'h01f4;
    localparam logic [3:0] RST_EEN = 4'hf;

    typedef struct packed {
        logic [15:0] il1, il2, il3, i01, i02, i1, i2, isum;
        logic [15:0] isum_ang, i01_ang, i02_ang;
    } cts_meas_s;

    typedef struct packed {
        logic [6:0] pad; // Fills the record to six full 32-bit words
        logic [47:0] ts;
        logic kind; // 0 alarm on, 1 block on
        logic [2:0] grp;
        logic [4:0] fault;
        logic [15:0] rem;
        logic [15:0] il1, il2, il3, i01, i02, i1, i2;
    } cts_rec_s;

    typedef struct packed {
        logic [15:0] high, low, rmm, run, dlim, dly;
        logic [1:0] sel;
        logic dir;
        logic [3:0] een;
        logic blk, start, alarm, blocked, hinh, linh;
        logic [15:0] tmr, cnt, mdiff, adiff;
        logic [4:0] fault;
        logic [3:0] wptr, lsel;
        cts_rec_s [LOG_DEPTH-1:0] log;
    } cts_inst_s;

    typedef struct packed {
        logic pu, hinh, linh;
        logic [4:0] fault;
        logic [15:0] mdiff, adiff;
    } cts_cnd_s;

    typedef struct packed {
        cts_inst_s [NINST-1:0] ins;
        logic [19:0] tick;
        logic ev;
        logic [31:0] rdata;
        logic [7:0] evt;
        logic [47:0] evt_ts;
    } cts_st_s;

    function automatic cts_st_s cts_rst_state();
        cts_st_s r;
        r = '0;
        for (int i = 0; i < NINST; i++) begin
            r.ins[i].high = RST_HIGH;
            r.ins[i].low = RST_LOW;
            r.ins[i].rmm = RST_RMM;
            r.ins[i].run = RST_RUN;
            r.ins[i].dlim = RST_DLIM;
            r.ins[i].dly = RST_DLY;
            r.ins[i].een = RST_EEN;
            r.ins[i].linh = 1'b1;
        end
        return r;
    endfunction
endpackage

/* tb/cts_meas_model.sv */
// Far-side model: measurement front end and blocking matrix for both supervisors
`timescale 1ns/1ps
`default_nettype none

module cts_meas_model
    import cts_pkg::*;
(
    input wire logic core_clk,
    input wire logic [5:0] scen,
    input wire logic [15:0] base,
    input wire logic [1:0] blk_req,
    output var cts_pkg::cts_meas_s [1:0] meas,
    output logic [1:0] block_in
);
    // Scenario table: 0 healthy, 1 secondary L1 open, 2 primary L1 open, 3 overcurrent unbalance, 4 low unbalance
    function automatic cts_meas_s pick(input logic [2:0] s, input logic [15:0] b);
        cts_meas_s m;
        m = '0;
        case (s)
            3'h0: begin
                m.il1 = b;
                m.il2 = b;
                m.il3 = b;
                m.i1 = b;
            end
            3'h1, 3'h2: begin
                m.il2 = 16'h0064;
                m.il3 = 16'h0064;
                m.i1 = 16'h0043;
                m.i2 = 16'h0021;
                m.isum = 16'h0064;
                m.i01 = (s == 3'h2) ? 16'h0064 : 16'h0000; // Healthy residual CT tracks the sum
            end
            3'h3: begin
                m.il2 = 16'h012c;
                m.il3 = 16'h012c;
                m.i1 = 16'h00c8;
                m.i2 = 16'h0064;
            end
            3'h4: begin
                m.il2 = 16'h0005;
                m.il3 = 16'h0005;
                m.i1 = 16'h0003;
                m.i2 = 16'h0002;
            end
            default: ;
        endcase
        return m;
    endfunction

    // Values move only on clock edges, like a sampled front end
    always_ff @(posedge core_clk) begin
        meas[0] <= pick(scen[2:0], base);
        meas[1] <= pick(scen[5:3], base);
        block_in <= blk_req; // Blocking follows the request one clock later, like the measurements
    end
endmodule

`default_nettype wire

/* tb/cts_supervisor_tb.sv */
// Self-checking testbench for the current transformer supervision block
`timescale 1ns/1ps
`default_nettype none

module cts_supervisor_tb;
    import cts_pkg::*;
    localparam int PC = 8;
    logic core_clk, rst_b, reg_wr, reg_rd;
    logic [6:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    cts_meas_s [1:0] meas;
    logic [1:0] block_in, blk_req, start_out, alarm_out, blocked_out;
    logic [7:0] event_out;
    logic [47:0] event_ts, rtc_ms;
    logic [2:0] set_group;
    logic [5:0] scen;
    logic [15:0] base;
    wire logic [5:0] stat = {blocked_out, alarm_out, start_out};
    int fails, checks_done, cyc, t0, t1;

    cts_supervisor #(.PROG_CYC(PC)) DUT (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas(meas),
        .block_in(block_in), .rtc_ms(rtc_ms), .set_group(set_group), .start_out(start_out),
        .alarm_out(alarm_out), .blocked_out(blocked_out), .event_out(event_out), .event_ts(event_ts));
    cts_meas_model far_side (.core_clk(core_clk), .scen(scen), .base(base), .blk_req(blk_req),
        .meas(meas), .block_in(block_in));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Cycle count doubles as millisecond stamp and hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        rtc_ms <= rtc_ms + 48'h0000_0000_0001;
        if (cyc == 20000) begin
            fails++;
            $display("Error at %0t: run did not finish", $time);
            results();
        end
    end

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [6:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic put(input logic [5:0] s, input logic [1:0] b);
        @(posedge core_clk);
        scen <= s;
        blk_req <= b;
        set_group <= 3'($urandom % 8);
    endtask

    task automatic evals(input int n);
        repeat (n * PC) @(posedge core_clk);
        #1;
    endtask

    // Bounded wait for one status level; bit order start[1:0], alarm[1:0], blocked[1:0]
    task automatic wait_rise(input int sel, output int t);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (stat[sel] !== 1'b1 && n < 100);
        if (n == 100) begin
            fails++;
            $display("Error at %0t: status bit %0d never rose", $time, sel);
        end
        t = cyc;
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, blk_req, scen, cyc, fails, checks_done} = '0;
        rtc_ms = '0;
        set_group = 3'h1;
        base = 16'h0064;
        void'($urandom(18537));
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        // Settings after reset, and an unmapped word
        rd(7'h00, d); chk(d, 48'h000a_0078);
        rd(7'h04, d); chk(d, 48'h1324_03e8);
        rd(7'h48, d); chk(d, 48'h00f0_000a);
        rd(7'h0c, d); chk(d, 48'h01f4);
        rd(7'h38, d); chk(d, 48'h0);
        wr(7'h0c, 32'h0000_0003);
        wr(7'h4c, 32'h0000_0003);
        // Random balanced load never picks up
        repeat (4) begin
            @(posedge core_clk);
            base <= 16'(50 + $urandom % 60);
            evals(3);
            chk(start_out, 2'b00);
        end
        // Open secondary in phase L1: start, then alarm after exactly three program cycles
        put(6'o01, 2'b00);
        wait_rise(0, t0);
        wait_rise(2, t1);
        chk(t1 - t0, 3 * PC);
        chk(event_out, 8'h01);
        chk(event_ts, rtc_ms - 48'h1);
        chk(alarm_out[1], 1'b0);
        wr(7'h1c, 32'h0);
        rd(7'h20, d); chk(d, 48'h0043_0021);
        rd(7'h14, d); chk(d[15:0], 48'h1);
        put(6'o00, 2'b00);
        evals(2);
        chk(stat[2:0], 3'b000);
        // Fault that heals before the delay expires
        put(6'o01, 2'b00);
        wait_rise(0, t0);
        evals(1);
        put(6'o00, 2'b00);
        evals(4);
        chk(alarm_out[0], 1'b0);
        // Overcurrent and low-current unbalance are both ignored
        put(6'o03, 2'b00);
        evals(4);
        chk(start_out[0], 1'b0);
        put(6'o04, 2'b00);
        evals(4);
        chk(start_out[0], 1'b0);
        put(6'o00, 2'b00);
        evals(2);
        // Blocking present before pick-up
        put(6'o00, 2'b01);
        evals(2);
        put(6'o01, 2'b01);
        wait_rise(4, t0);
        chk(start_out[0], 1'b0);
        evals(4);
        chk(alarm_out[0], 1'b0);
        put(6'o00, 2'b00);
        evals(2);
        // Blocking arriving after start
        put(6'o01, 2'b00);
        wait_rise(0, t0);
        put(6'o01, 2'b01);
        wait_rise(4, t0);
        chk(start_out[0], 1'b0);
        chk(alarm_out[0], 1'b0);
        put(6'o00, 2'b00);
        evals(2);
        rd(7'h14, d); chk(d[15:0], 48'h3);
        wr(7'h14, 32'h0);
        rd(7'h14, d); chk(d[15:0], 48'h0);
        // Residual channel one in use
        wr(7'h08, 32'h00f1_000a);
        put(6'o02, 2'b00);
        evals(4);
        chk(start_out[0], 1'b0);
        rd(7'h18, d); chk(d[15:0], 48'h0);
        put(6'o01, 2'b00);
        wait_rise(0, t0);
        rd(7'h18, d); chk(d[15:0], 48'h64);
        // Second residual channel with reversed polarity turns the angle by half a turn
        wr(7'h08, 32'h00f6_000a);
        rd(7'h18, d); chk(d, 48'h4650_0064);
        // Second instance works on its own
        put(6'o10, 2'b00);
        wait_rise(3, t1);
        chk(alarm_out[1], 1'b1);
        results();
    end
endmodule

`default_nettype wire
